// ===== src/fbpm_params.svh
`ifndef FBPM_PARAMS_SVH
`define FBPM_PARAMS_SVH

// ***********************************************
// timebase
// ***********************************************
`define FBPM_CLK_PERIOD_PS 5000

// ***********************************************
// documented times, in their own units
// ***********************************************
`define FBPM_STOP_TIME_NS 30
`define FBPM_SLEEP_ENTRY_TIME_US 10
`define FBPM_SLEEP_EXIT_TIME_US 300
`define FBPM_RESET_PULSE_MIN_NS 200

// ***********************************************
// derived cycle counts (least times round up, longest down)
// ***********************************************
`define FBPM_STOP_CYC ((`FBPM_STOP_TIME_NS * 1000 + `FBPM_CLK_PERIOD_PS - 1) / `FBPM_CLK_PERIOD_PS)
`define FBPM_ENTRY_CYC ((`FBPM_SLEEP_ENTRY_TIME_US * 1000000 + `FBPM_CLK_PERIOD_PS - 1) / `FBPM_CLK_PERIOD_PS)
`define FBPM_EXIT_CYC ((`FBPM_SLEEP_EXIT_TIME_US * 1000000) / `FBPM_CLK_PERIOD_PS)
`define FBPM_RP_CYC ((`FBPM_RESET_PULSE_MIN_NS * 1000 + `FBPM_CLK_PERIOD_PS - 1) / `FBPM_CLK_PERIOD_PS)

// ***********************************************
// volatile configuration register
// ***********************************************
`define FBPM_CR_SLEEP_BIT 15
`define FBPM_CR_RESET 16'hFFFF

`endif

// ===== src/fbpm_pkg.sv
package fbpm_pkg;

  typedef enum logic [1:0] {
    PM_RUN,
    PM_ENTRY,
    PM_SLEEP,
    PM_WAKE
  } fbpm_pm_t;

  typedef logic [15:0] fbpm_cr_t;

endpackage : fbpm_pkg

// ===== src/fbpm_xdom_if.sv
`timescale 1ns/1ps
interface fbpm_xdom_if;
  // toggles on every rising link clock edge, read in the system domain
  logic ck_toggle;
  // transaction block from the system domain
  logic blocked;

  modport link (
    output ck_toggle,
    input blocked
  );

  modport core (
    input ck_toggle,
    output blocked
  );
endinterface : fbpm_xdom_if

// ===== src/fbpm_sync.sv
`timescale 1ns/1ps
module fbpm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : fbpm_sync

// ===== src/fbpm_link.sv
`timescale 1ns/1ps
module fbpm_link (
  input wire logic host_bus_clock,
  input wire logic nrst,
  fbpm_xdom_if.link xd,
  input wire logic rd_active,
  input wire logic [7:0] rd_byte,
  output logic [7:0] dq_out,
  output logic dq_oe,
  output logic read_strobe_out,
  output logic read_strobe_oe
);
  logic ck_toggle_r;
  logic blk_meta_r;
  logic blocked_s;
  logic [7:0] dq_r;
  logic strobe_r;

  // ***********************************************
  // block flag crossing
  // ***********************************************
  // set at once: the bus clock may be stopped when the block rises, and
  // even the first edge of an attempted read must not move the strobe;
  // release still passes two link edges
  always_ff @(posedge host_bus_clock or negedge nrst or posedge xd.blocked) begin
    if (!nrst) begin
      blk_meta_r <= 1'b0;
      blocked_s <= 1'b0;
    end else if (xd.blocked) begin
      blk_meta_r <= 1'b1;
      blocked_s <= 1'b1;
    end else begin
      blk_meta_r <= 1'b0;
      blocked_s <= blk_meta_r;
    end
  end

  // ***********************************************
  // clock activity marker
  // ***********************************************
  always_ff @(posedge host_bus_clock or negedge nrst) begin
    if (!nrst) begin
      ck_toggle_r <= 1'b0;
    end else begin
      ck_toggle_r <= ~ck_toggle_r;
    end
  end
  assign xd.ck_toggle = ck_toggle_r;

  // ***********************************************
  // read output
  // ***********************************************
  // no edges while the clock stands, so the byte simply stays latched
  always_ff @(posedge host_bus_clock or negedge nrst) begin
    if (!nrst) begin
      dq_r <= 8'h00;
    end else if (rd_active && !blocked_s) begin
      dq_r <= rd_byte;
    end
  end

  // strobe frozen while blocked, even on an attempted read
  always_ff @(posedge host_bus_clock or negedge nrst) begin
    if (!nrst) begin
      strobe_r <= 1'b0;
    end else if (rd_active && !blocked_s) begin
      strobe_r <= ~strobe_r;
    end else if (!rd_active) begin
      strobe_r <= 1'b0;
    end
  end

  assign dq_out = dq_r;
  assign dq_oe = rd_active && !blocked_s;
  assign read_strobe_out = strobe_r;
  assign read_strobe_oe = rd_active;
endmodule : fbpm_link

// ===== src/fbpm_top.sv
// Functional notes
// - clock quiet 30 ns during read: clock stop
// - clock stop holds and drives output byte
// - clock toggling again resumes the read
// - algorithm controller ignores clock stop state
// - config bit 15 written zero starts entry
// - entry period ignores select and transactions
// - commands cannot abort entry into sleep
// - wake period: no transactions, strobe frozen
// - reset pulse leaves sleep, then wake period
// - reset pulse during entry aborts entry
// - leaving sleep restores power-on configuration
`timescale 1ns/1ps
`include "fbpm_params.svh"
module fbpm_top #(
  parameter int unsigned EXIT_CYC = `FBPM_EXIT_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic host_bus_clock,
  input wire logic select_n,
  input wire logic hw_reset_n,
  input wire logic rd_active,
  input wire logic [7:0] rd_byte,
  output logic [7:0] dq_out,
  output logic dq_oe,
  output logic read_strobe_out,
  output logic read_strobe_oe,
  input wire logic cr_wr,
  input wire fbpm_pkg::fbpm_cr_t cr_wr_data,
  input wire logic standby_idle,
  input wire logic alternate_space_overlay,
  output fbpm_pkg::fbpm_cr_t volatile_config_reg,
  output logic cfg_default_load,
  output logic cmd_enable,
  output logic clock_stop,
  output logic deep_sleep,
  output logic eac_run_en
);
  import fbpm_pkg::*;

  localparam logic [3:0] STOP_CYC = 4'(`FBPM_STOP_CYC);
  localparam logic [15:0] ENTRY_CYC = 16'(`FBPM_ENTRY_CYC);
  localparam logic [15:0] WAKE_CYC = 16'(EXIT_CYC);
  localparam logic [5:0] RP_CYC = 6'(`FBPM_RP_CYC);

  fbpm_xdom_if xd ();

  logic ck_toggle_s;
  logic ck_toggle_d_r;
  logic rd_active_s;
  logic select_n_s;
  logic select_n_d_r;
  logic hw_reset_n_s;
  logic ck_moved;
  logic select_fall;
  logic rst_hit;
  logic [3:0] quiet_cnt_r;
  logic clock_stop_r;
  logic [5:0] rp_cnt_r;
  logic [15:0] tmr_r;
  logic tmr_done;
  fbpm_pm_t pm_r;
  fbpm_pm_t pm_nxt;
  fbpm_cr_t cr_r;
  logic default_load_r;
  logic sleep_req;
  logic blocked_r;
  logic cmd_en_r;
  logic sleep_r;
  logic eac_en_r;

  // ***********************************************
  // link-side logic
  // ***********************************************
  fbpm_link u_link (
    .host_bus_clock(host_bus_clock),
    .nrst(nrst),
    .xd(xd.link),
    .rd_active(rd_active),
    .rd_byte(rd_byte),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .read_strobe_out(read_strobe_out),
    .read_strobe_oe(read_strobe_oe)
  );

  // ***********************************************
  // input synchronisers
  // ***********************************************
  // pins and link-domain levels; hw_reset_n resets to low, so a pin held
  // low from power-up is counted as a reset pulse from reset onward
  fbpm_sync #(.W(3)) u_in_sync (
    .clk(clk_sys),
    .nrst(nrst),
    .d({xd.ck_toggle, rd_active, select_n}),
    .q({ck_toggle_s, rd_active_s, select_n_s})
  );

  fbpm_sync #(.W(1)) u_rst_sync (
    .clk(clk_sys),
    .nrst(nrst),
    .d(hw_reset_n),
    .q(hw_reset_n_s)
  );

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ck_toggle_d_r <= 1'b0;
      // matches the synchroniser's reset output, so no false fall
      // shows while it fills after reset
      select_n_d_r <= 1'b0;
    end else begin
      ck_toggle_d_r <= ck_toggle_s;
      select_n_d_r <= select_n_s;
    end
  end

  assign ck_moved = ck_toggle_s != ck_toggle_d_r;
  assign select_fall = select_n_d_r && !select_n_s;

  // ***********************************************
  // clock stop detection
  // ***********************************************
  // the bus clock cannot time its own absence, so the quiet window is
  // counted on clk_sys
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      quiet_cnt_r <= 4'h0;
    end else if (ck_moved || !rd_active_s) begin
      quiet_cnt_r <= 4'h0;
    end else if (quiet_cnt_r != STOP_CYC) begin
      quiet_cnt_r <= quiet_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clock_stop_r <= 1'b0;
    end else if (ck_moved || !rd_active_s) begin
      clock_stop_r <= 1'b0;
    end else if (quiet_cnt_r == STOP_CYC - 4'h1) begin
      clock_stop_r <= 1'b1;
    end
  end

  assign clock_stop = clock_stop_r;

  // ***********************************************
  // hardware reset pulse width
  // ***********************************************
  // a glitch shorter than the minimum width must not disturb sleep
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rp_cnt_r <= 6'h00;
    end else if (hw_reset_n_s) begin
      rp_cnt_r <= 6'h00;
    end else if (rp_cnt_r != RP_CYC) begin
      rp_cnt_r <= rp_cnt_r + 6'h01;
    end
  end

  assign rst_hit = !hw_reset_n_s && (rp_cnt_r == RP_CYC - 6'h01);

  // ***********************************************
  // sleep request qualification
  // ***********************************************
  // host keeps the idle and overlay conditions; the device checks them
  // anyway so a stray write cannot strand a busy algorithm
  assign sleep_req = cr_wr && !cr_wr_data[`FBPM_CR_SLEEP_BIT]
                     && standby_idle && !alternate_space_overlay;

  // ***********************************************
  // power mode sequencer
  // ***********************************************
  assign tmr_done = tmr_r == 16'h0000;

  always_comb begin
    pm_nxt = pm_r;
    case (pm_r)
      PM_RUN: begin
        if (sleep_req) begin
          pm_nxt = PM_ENTRY;
        end
      end
      PM_ENTRY: begin
        // select and commands are not looked at here
        if (rst_hit) begin
          pm_nxt = PM_RUN;
        end else if (tmr_done) begin
          pm_nxt = PM_SLEEP;
        end
      end
      PM_SLEEP: begin
        // a select only reaches here after the entry period
        if (rst_hit || select_fall) begin
          pm_nxt = PM_WAKE;
        end
      end
      PM_WAKE: begin
        if (tmr_done) begin
          pm_nxt = PM_RUN;
        end
      end
      default: begin
        pm_nxt = PM_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pm_r <= PM_RUN;
    end else begin
      pm_r <= pm_nxt;
    end
  end

  // one down-counter serves both the entry and the wake window
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tmr_r <= 16'h0000;
    end else if (pm_r == PM_RUN && pm_nxt == PM_ENTRY) begin
      tmr_r <= ENTRY_CYC - 16'h0001;
    end else if (pm_r == PM_SLEEP && pm_nxt == PM_WAKE) begin
      tmr_r <= WAKE_CYC - 16'h0001;
    end else if (!tmr_done) begin
      tmr_r <= tmr_r - 16'h0001;
    end
  end

  // ***********************************************
  // volatile configuration register
  // ***********************************************
  // defaults reload on wake completion and on an aborted entry, since
  // the reset pulse that aborts it also restores power-on settings
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      default_load_r <= 1'b0;
    end else begin
      default_load_r <= (pm_r == PM_WAKE && pm_nxt == PM_RUN)
                        || (pm_r == PM_ENTRY && pm_nxt == PM_RUN);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cr_r <= `FBPM_CR_RESET;
    end else if (pm_nxt == PM_RUN && pm_r != PM_RUN) begin
      cr_r <= `FBPM_CR_RESET;
    end else if (pm_r == PM_RUN && cr_wr) begin
      cr_r <= cr_wr_data;
    end
  end

  assign volatile_config_reg = cr_r;
  assign cfg_default_load = default_load_r;

  // ***********************************************
  // status and gating
  // ***********************************************
  // decoded from the next state, so these flops line up with pm_r and
  // the link sees a glitch-free block level it may set on asynchronously
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      blocked_r <= 1'b0;
    end else begin
      blocked_r <= pm_nxt != PM_RUN;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmd_en_r <= 1'b1;
    end else begin
      cmd_en_r <= pm_nxt == PM_RUN;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sleep_r <= 1'b0;
    end else begin
      sleep_r <= pm_nxt == PM_SLEEP;
    end
  end

  // clock stop deliberately kept out of this term
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      eac_en_r <= 1'b1;
    end else begin
      eac_en_r <= pm_nxt == PM_RUN;
    end
  end

  assign xd.blocked = blocked_r;
  assign cmd_enable = cmd_en_r;
  assign deep_sleep = sleep_r;
  assign eac_run_en = eac_en_r;
endmodule : fbpm_top

// ===== verification/fbpm_host_model.sv
`timescale 1ns/1ps
// *****
// host side: bus clock only runs inside frames
// *****
module fbpm_host_model (
  output logic host_bus_clock,
  output logic select_n,
  output logic hw_reset_n,
  output logic rd_active,
  output logic [7:0] rd_byte
);
  initial begin
    host_bus_clock = 1'b0;
    select_n = 1'b1;
    hw_reset_n = 1'b1;
    rd_active = 1'b0;
    rd_byte = 8'h5A;
  end

  // reads only: the slow write-load clock grade never arises here
  task automatic burst(input int n, input bit stall);
    #3.3;
    select_n = 1'b0;
    rd_active = 1'b1;
    for (int i = 0; i < n; i++) begin
      rd_byte = 8'hA0 + 8'(i);
      #40 host_bus_clock = 1'b1; // equal halves
      #40 host_bus_clock = 1'b0;
      if (stall && i == 0) #300;
    end
    rd_active = 1'b0;
    select_n = 1'b1;
    // released data must not look like the last byte
    rd_byte = ~rd_byte;
  endtask : burst

  task automatic sel_pulse();
    #3.3 select_n = 1'b0;
    #100 select_n = 1'b1;
  endtask : sel_pulse

  task automatic rst_pulse();
    hw_reset_n = 1'b0;
    #300 hw_reset_n = 1'b1;
  endtask : rst_pulse
endmodule : fbpm_host_model

// ===== verification/fbpm_top_sva.sv
`timescale 1ns/1ps
`include "fbpm_params.svh"
// *****
// power mode checks
// *****
module fbpm_top_sva #(
  parameter int unsigned EXIT_CYC = `FBPM_EXIT_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic host_bus_clock,
  input wire logic rd_active,
  input wire logic cr_wr,
  input wire fbpm_pkg::fbpm_cr_t cr_wr_data,
  input wire logic standby_idle,
  input wire logic alternate_space_overlay,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  input wire fbpm_pkg::fbpm_cr_t volatile_config_reg,
  input wire logic cfg_default_load,
  input wire logic cmd_enable,
  input wire logic clock_stop,
  input wire logic deep_sleep,
  input wire logic eac_run_en
);
  import fbpm_pkg::*;
  logic seen_r;
  logic [11:0] ent_r;
  logic [15:0] wk_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // tells entry from wake: both block commands outside sleep
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) seen_r <= 1'b0;
    else if (deep_sleep) seen_r <= 1'b1;
    else if (cmd_enable) seen_r <= 1'b0;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) ent_r <= '0;
    else ent_r <= (!cmd_enable && !deep_sleep && !seen_r) ? ent_r + 12'h1 : '0;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) wk_r <= '0;
    else wk_r <= (!cmd_enable && !deep_sleep && seen_r) ? wk_r + 16'h1 : '0;
  end

  sleep_cmd_a: assert property (cr_wr && !cr_wr_data[`FBPM_CR_SLEEP_BIT] && standby_idle
    && !alternate_space_overlay && cmd_enable |=> !cmd_enable && !eac_run_en)
    else $error("sleep request not taken");
  entry_len_a: assert property ($rose(deep_sleep) |-> ent_r == `FBPM_ENTRY_CYC)
    else $error("entry period length wrong");
  entry_max_a: assert property (ent_r <= `FBPM_ENTRY_CYC)
    else $error("entry period overran");
  wake_len_a: assert property ($rose(cmd_enable) && seen_r |-> wk_r == EXIT_CYC)
    else $error("wake period length wrong");
  cfg_dflt_a: assert property ($rose(cmd_enable) |-> volatile_config_reg == `FBPM_CR_RESET)
    else $error("defaults not restored");
  // the load flag is registered on the same edge that reopens commands
  dflt_pulse_a: assert property ($rose(cmd_enable) |-> cfg_default_load)
    else $error("default load pulse missing");
  eac_indep_a: assert property (clock_stop |-> eac_run_en == cmd_enable)
    else $error("algorithm gated by clock stop");
  dq_hold_a: assert property (clock_stop && rd_active && cmd_enable
    && $stable(host_bus_clock) |-> dq_oe && $stable(dq_out))
    else $error("output byte not held");
  stop_entry_a: assert property ((rd_active && cmd_enable
    && $stable(host_bus_clock))[*8] |-> ##[0:6] clock_stop)
    else $error("clock stop not entered");
  stop_exit_a: assert property (clock_stop && $rose(host_bus_clock)
    |-> ##[1:4] !clock_stop)
    else $error("clock stop not left");

  cover property ($rose(deep_sleep));
  cover property ($rose(clock_stop));
  cover property ($rose(cfg_default_load));
endmodule : fbpm_top_sva

bind fbpm_top fbpm_top_sva #(.EXIT_CYC(EXIT_CYC)) i_fbpm_top_sva (.clk_sys, .nrst,
  .host_bus_clock, .rd_active, .cr_wr, .cr_wr_data, .standby_idle, .alternate_space_overlay,
  .dq_out, .dq_oe, .volatile_config_reg, .cfg_default_load, .cmd_enable, .clock_stop,
  .deep_sleep, .eac_run_en);

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
  import fbpm_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic cr_wr = 1'b0;
  logic standby_idle = 1'b1;
  logic alternate_space_overlay = 1'b0;
  fbpm_cr_t cr_wr_data = 16'hFFFF;
  wire logic host_bus_clock, select_n, hw_reset_n, rd_active;
  wire logic [7:0] rd_byte;
  logic [7:0] dq_out;
  logic dq_oe, read_strobe_out, read_strobe_oe, cfg_default_load;
  logic cmd_enable, clock_stop, deep_sleep, eac_run_en;
  fbpm_cr_t volatile_config_reg;
  int error_cnt = 0;
  int compares = 0;

  always #2.5 clk_sys = ~clk_sys;

  fbpm_host_model i_fbpm_host_model (.host_bus_clock, .select_n, .hw_reset_n, .rd_active,
    .rd_byte);
  // short wake window keeps the run brief
  fbpm_top #(.EXIT_CYC(200)) i_fbpm_top (.clk_sys, .nrst, .host_bus_clock, .select_n,
    .hw_reset_n, .rd_active, .rd_byte, .dq_out, .dq_oe, .read_strobe_out, .read_strobe_oe,
    .cr_wr, .cr_wr_data, .standby_idle, .alternate_space_overlay, .volatile_config_reg,
    .cfg_default_load, .cmd_enable, .clock_stop, .deep_sleep, .eac_run_en);

  // *****
  // helpers
  // *****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wait_run();
    for (int i = 0; i < 400 && cmd_enable !== 1'b1; i++) tick(1);
  endtask : wait_run

  task automatic sleep_req(input fbpm_cr_t d);
    tick(1);
    cr_wr_data = d;
    cr_wr = 1'b1;
    tick(1);
    cr_wr = 1'b0;
  endtask : sleep_req

  task automatic complete_run();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // *****
  // scenarios
  // *****
  task automatic t_refuse();
    for (int k = 0; k < 2; k++) begin
      standby_idle = k[0];
      alternate_space_overlay = k[0];
      sleep_req(16'h7FF0);
      tick(3);
      chk(cmd_enable, 1'b1);
      chk(volatile_config_reg, 16'h7FF0);
    end
    standby_idle = 1'b1;
    alternate_space_overlay = 1'b0;
  endtask : t_refuse

  task automatic t_cstop();
    fork
      i_fbpm_host_model.burst(4, 1'b1);
      begin
        for (int i = 0; i < 200 && !(clock_stop === 1'b1 && dq_out === 8'hA0); i++) tick(1);
        chk(clock_stop, 1'b1);
        chk(dq_out, 8'hA0);
        chk(dq_oe, 1'b1);
        chk(eac_run_en, 1'b1);
        chk(read_strobe_oe, 1'b1);
      end
    join
    chk(dq_out, 8'hA3);
  endtask : t_cstop

  task automatic t_sleep_sel();
    logic s;
    logic [7:0] d;
    sleep_req(16'h7FFF);
    chk(cmd_enable, 1'b0);
    chk(eac_run_en, 1'b0);
    tick(20);
    sleep_req(16'hFFFF);
    i_fbpm_host_model.sel_pulse();
    tick(2100);
    chk(deep_sleep, 1'b1);
    i_fbpm_host_model.sel_pulse();
    fork
      i_fbpm_host_model.burst(6, 1'b0);
      begin
        // taken before the first link edge of the attempted read
        #30 s = read_strobe_out;
        d = dq_out;
        #370 chk(read_strobe_out, s);
        chk(dq_out, d);
        chk(dq_oe, 1'b0);
        chk(cmd_enable, 1'b0);
      end
    join
    wait_run();
    chk(volatile_config_reg, 16'hFFFF);
  endtask : t_sleep_sel

  task automatic t_sleep_rst();
    sleep_req(16'h7FFF);
    tick(2050);
    chk(deep_sleep, 1'b1);
    i_fbpm_host_model.rst_pulse();
    chk(deep_sleep, 1'b0);
    wait_run();
    chk(cmd_enable, 1'b1);
    chk(volatile_config_reg, 16'hFFFF);
  endtask : t_sleep_rst

  task automatic t_abort();
    sleep_req(16'h7FFF);
    tick(100);
    i_fbpm_host_model.rst_pulse();
    wait_run();
    chk(cmd_enable, 1'b1);
    chk(volatile_config_reg, 16'hFFFF);
    tick(2000);
    chk(deep_sleep, 1'b0);
  endtask : t_abort

  initial begin
    tick(6);
    nrst = 1'b1;
    chk(volatile_config_reg, 16'hFFFF);
    chk(cmd_enable, 1'b1);
    t_refuse();
    t_cstop();
    t_sleep_sel();
    t_sleep_rst();
    t_abort();
    complete_run();
  end

  // about nine times the expected run
  initial begin
    #300000;
    error_cnt++;
    complete_run();
  end
endmodule : tb
